// ### dpit_pkg.sv
// Constants, types and register map of the dual-op issue timing block.
// Assumes one core clock; instruction details arrive from the issue stage.
package dpit_pkg;
  localparam int AW = 8;
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_R1     = 8'h08;
  localparam logic [7:0] OFF_R2     = 8'h0C;
  localparam logic [7:0] OFF_RL     = 8'h10;
  localparam logic [7:0] OFF_KR     = 8'h14;
  localparam logic [7:0] OFF_KI     = 8'h18;
  localparam logic [7:0] OFF_TEMP   = 8'h1C;
  localparam int CTRL_VARIANT = 0;
  localparam int CTRL_DUAL    = 1;
  localparam logic [1:0] CTRL_RST = 2'h3;
  localparam logic [3:0] CLK_ONE   = 4'h1;
  localparam logic [3:0] CLK_TWO   = 4'h2;
  localparam logic [3:0] CLK_THREE = 4'h3;
  localparam logic [2:0] DRAIN_SP  = 3'h2;
  localparam logic [2:0] DRAIN_DP  = 3'h3;
  localparam logic [3:0] TLB_FIXED = 4'h5;
  localparam logic [3:0] TLB_READS = 4'h2;
  localparam logic [3:0] LINE_BEATS = 4'h4;
  localparam logic [3:0] ICD_MISS  = 4'h2;
  localparam logic [3:0] ICD_HIT   = 4'h1;

  typedef enum logic [3:0] {
    CL_PLAIN, CL_BC, CL_BCT, CL_LOOP, CL_BTE, CL_BR, CL_BRI,
    CL_CALL, CL_CALLI, CL_GFX, CL_LADD, CL_FP
  } dpit_class_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_FRESH = 4'b0010,
    ST_BUS   = 4'b0100,
    ST_CNT   = 4'b1000
  } dpit_state_t;

  typedef enum logic [1:0] {M1_KR, M1_KI, M1_SOURCE_ONE} dpit_m1_t;
  typedef enum logic [1:0] {A1_SOURCE_ONE, A1_TEMP, A1_ARES, A1_SOURCE_TWO} dpit_a1_t;
  typedef enum logic [1:0] {A2_MRES, A2_ARES, A2_SOURCE_ONE} dpit_a2_t;

  typedef struct packed {
    dpit_m1_t m1;
    dpit_a1_t a1;
    dpit_a2_t a2;
    logic     k_ld;
    logic     t_ld;
  } dpit_route_t;
endpackage : dpit_pkg

// ### dpit_issue_timing.sv
// Issue timing, freeze control and dual-op operand routing of the core.
// Assumes bus pins and issue-stage inputs are synchronous to pclk.
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
module dpit_issue_timing (
  // Clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [dpit_pkg::AW-1:0]  paddr,
  input  wire logic [31:0]              pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Issue stage, first slot
  input  wire logic                     issue_valid,
  input  wire dpit_pkg::dpit_class_t    slot_a_class,
  input  wire logic                     slot_a_taken,
  input  wire logic                     slot_a_prior_arith,
  input  wire logic                     slot_a_next_ma,
  input  wire logic                     slot_a_next_g,
  input  wire logic                     slot_a_move,
  // Issue stage, second slot of a dual pair
  input  wire logic                     dual_valid,
  input  wire dpit_pkg::dpit_class_t    slot_b_class,
  input  wire logic                     slot_b_taken,
  input  wire logic                     slot_b_prior_arith,
  input  wire logic                     slot_b_next_ma,
  input  wire logic                     slot_b_next_g,
  input  wire logic                     slot_b_move,
  // Freeze causes, and store path inputs; stores_waiting and wb_waiting only reach the status register
  input  wire logic                     dload_miss,
  input  wire logic                     dload_128,
  input  wire logic                     scalar_issue,
  input  wire logic                     scalar_dmul,
  input  wire logic                     fp_consumer,
  input  wire logic                     prec_overlap,
  input  wire logic                     pipe_dest_nonzero,
  input  wire logic                     tlb_miss,
  input  wire logic                     abit_update,
  input  wire logic                     icache_miss,
  input  wire logic                     line_has_ctl,
  input  wire logic                     dcache_busy,
  input  wire logic                     dcache_hit,
  input  wire logic                     addr_waiting,
  input  wire logic [1:0]               stores_waiting,
  input  wire logic                     wb_waiting,
  input  wire logic                     bus_pipe_full,
  // External bus pins
  input  wire logic                     address_strobe_n,
  input  wire logic                     burst_ready_n,
  input  wire logic                     repeated_addr,
  // Dual-op datapath
  input  wire logic                     dp_valid,
  input  wire logic [3:0]               datapath_control_code,
  input  wire logic [31:0]              source_one,
  input  wire logic [31:0]              add_result,
  output dpit_pkg::dpit_m1_t            mul_op1_sel,
  output dpit_pkg::dpit_a1_t            add_op1_sel,
  output dpit_pkg::dpit_a2_t            add_op2_sel,
  // Issue status
  output logic                          issue_ready,
  output logic                          issue_done,
  output logic                          freeze
);
  import dpit_pkg::*;

  typedef struct packed {
    dpit_state_t st;
    logic        ready;
    logic        frz;
    logic        done;
    logic [3:0]  cnt;
    logic [3:0]  rdy;
    logic [2:0]  drain;
    logic [1:0]  ctrl;
    logic        meas_on;
    logic [7:0]  meas;
    logic [3:0]  beat;
    logic [7:0]  r1;
    logic [7:0]  r2;
    logic [7:0]  rl;
    logic [31:0] kr;
    logic [31:0] ki;
    logic [31:0] tmp;
    dpit_route_t rt;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } dpit_regs_t;

  dpit_regs_t s_q;
  dpit_regs_t s_d;

  function automatic logic [3:0] slot_clocks(
    input dpit_class_t c, input logic tk, input logic pr,
    input logic ma, input logic g, input logic mv);
    logic [3:0] r;
    r = CLK_ONE;
    case (c)
      CL_BC:    r = (tk ? CLK_TWO : CLK_ONE) + {3'h0, pr};
      CL_BCT:   r = (tk ? CLK_ONE : CLK_TWO) + {3'h0, pr};
      CL_LOOP:  r = tk ? CLK_ONE : CLK_TWO;
      CL_BTE:   r = tk ? CLK_THREE : CLK_ONE;
      CL_BRI:   r = CLK_TWO;
      CL_CALL:  r = CLK_ONE + {3'h0, ma};
      CL_CALLI: r = CLK_TWO + {3'h0, ma};
      CL_GFX:   r = CLK_ONE + {3'h0, ma | g};
      CL_LADD:  r = CLK_ONE + {3'h0, ma & ~mv} + {3'h0, g};
      default:  r = CLK_ONE;
    endcase
    return r;
  endfunction : slot_clocks

  function automatic dpit_route_t route(input logic [3:0] code);
    dpit_route_t r;
    r = '{M1_KR, A1_SOURCE_ONE, A2_MRES, 1'b0, 1'b0};
    case (code)
      4'h8: r = '{M1_KR, A1_ARES, A2_SOURCE_ONE, 1'b0, 1'b0};
      4'h9: r = '{M1_SOURCE_ONE, A1_SOURCE_TWO, A2_MRES, 1'b0, 1'b0};
      4'hA: r = '{M1_KR, A1_SOURCE_ONE, A2_MRES, 1'b0, 1'b0};
      4'hB: r = '{M1_SOURCE_ONE, A1_TEMP, A2_ARES, 1'b0, 1'b1};
      default:
      begin
        if (!code[3])
        begin
          r.m1   = code[2] ? M1_KI : M1_KR;
          r.a1   = code[0] ? A1_TEMP : A1_SOURCE_ONE;
          r.k_ld = code[0];
          r.a2   = code[1] ? A2_ARES : A2_MRES;
          r.t_ld = code[1];
        end
      end
    endcase
    return r;
  endfunction : route

  // Derived freeze terms for the instruction being offered
  logic       acc;
  logic [3:0] fa;
  logic [3:0] fb;
  logic [3:0] n_w;
  logic [3:0] ext_w;
  logic [3:0] rdy_w;
  logic       fresh_w;
  logic       call_miss;
  logic       addr_full;
  logic       store_full;
  logic       drain_adj;
  logic       dual_on;
  logic [3:0] drain_add;

  assign acc = issue_valid & s_q.ready;
  assign dual_on = dual_valid & s_q.ctrl[CTRL_DUAL];
  assign fa = slot_clocks(slot_a_class, slot_a_taken, slot_a_prior_arith,
                          slot_a_next_ma, slot_a_next_g, slot_a_move);
  assign fb = dual_on ? slot_clocks(slot_b_class, slot_b_taken,
                          slot_b_prior_arith, slot_b_next_ma,
                          slot_b_next_g, slot_b_move) : CLK_ONE;
  assign n_w = (fb > fa) ? fb : fa;
  assign addr_full = addr_waiting & bus_pipe_full;
  assign store_full = (stores_waiting[1] | wb_waiting)
                      & bus_pipe_full;
  assign call_miss = dload_miss
                     & (slot_a_class == CL_CALL | slot_a_class == CL_CALLI);
  assign drain_adj = prec_overlap | pipe_dest_nonzero;
  // Remaining drain already counts the clocks spent since the scalar op
  assign drain_add = (fp_consumer && s_q.drain != 3'h0)
                     ? {1'b0, s_q.drain} + {3'h0, drain_adj}
                     : 4'h0;
  assign ext_w = (n_w - CLK_ONE) + drain_add
               + (tlb_miss ? TLB_FIXED : 4'h0)
               + {3'h0, call_miss}
               + ((icache_miss & dcache_busy)
                  ? (dcache_hit ? ICD_HIT : ICD_MISS)
                  : 4'h0);
  assign rdy_w = (call_miss ? (dload_128 ? 4'h2 : 4'h1) : 4'h0)
               + (icache_miss
                  ? ((s_q.ctrl[CTRL_VARIANT] & line_has_ctl)
                     ? LINE_BEATS : 4'h1) : 4'h0)
               + (tlb_miss ? TLB_READS + {3'h0, abit_update}
                           : 4'h0);
  assign fresh_w = s_q.ctrl[CTRL_VARIANT] & addr_full;

  function automatic logic [31:0] rd_mux(input logic [AW-1:0] a,
                                         input dpit_regs_t s);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      OFF_CTRL:   v = {30'h0, s.ctrl};
      OFF_STATUS: v = {24'h0, s.drain, store_full, addr_full,
                       s.frz, s.st[3:2]};
      OFF_R1:     v = {24'h0, s.r1};
      OFF_R2:     v = {24'h0, s.r2};
      OFF_RL:     v = {24'h0, s.rl};
      OFF_KR:     v = s.kr;
      OFF_KI:     v = s.ki;
      OFF_TEMP:   v = s.tmp;
      default:    v = 32'h0000_0000;
    endcase
    return v;
  endfunction : rd_mux

  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    // APB: answer in the first access cycle, no wait states
    if (psel && !penable)
    begin
      s_d.pready = 1'b1;
      s_d.prdata = rd_mux(paddr, s_q);
      s_d.pslverr = !(paddr[1:0] == 2'h0 && paddr <= OFF_TEMP);
    end
    if (psel && penable && s_q.pready && pwrite && !s_q.pslverr)
    begin
      case (paddr)
        OFF_CTRL: s_d.ctrl = pwdata[1:0];
        OFF_KR:   s_d.kr = pwdata;
        OFF_KI:   s_d.ki = pwdata;
        default:  s_d.ctrl = s_q.ctrl;
      endcase
    end
    // Bus interval measurement from strobe to the first, second and last ready
    if (s_q.meas_on)
    begin
      s_d.meas = s_q.meas + 8'h01;
      if (!burst_ready_n)
      begin
        s_d.beat = s_q.beat + 4'h1;
        if (s_q.beat == 4'h0)
          s_d.r1 = s_d.meas;
        if (s_q.beat == 4'h1)
          s_d.r2 = s_d.meas;
        if (s_q.beat == LINE_BEATS - 4'h1)
        begin
          s_d.rl = s_d.meas;
          s_d.meas_on = 1'b0;
        end
      end
    end
    if (!address_strobe_n)
    begin
      s_d.meas = 8'h01;
      s_d.beat = 4'h0;
      s_d.meas_on = 1'b1;
    end
    // Scalar drain window shrinks with every clock that passes
    if (s_q.drain != 3'h0)
      s_d.drain = s_q.drain - 3'h1;
    // Issue sequencing; ST_IDLE is left only on acceptance
    case (s_q.st)
      ST_IDLE:
      begin
        if (acc)
        begin
          s_d.cnt = ext_w;
          s_d.rdy = rdy_w;
          if (scalar_issue)
            s_d.drain = scalar_dmul ? DRAIN_DP : DRAIN_SP;
          if (fresh_w)
            s_d.st = ST_FRESH;
          else if (rdy_w != 4'h0)
            s_d.st = ST_BUS;
          else if (ext_w != 4'h0)
            s_d.st = ST_CNT;
          else
            s_d.done = 1'b1;
          if (dp_valid)
          begin
            s_d.rt = route(datapath_control_code);
            if (s_d.rt.k_ld && s_d.rt.m1 == M1_KI)
              s_d.ki = source_one;
            else if (s_d.rt.k_ld && s_d.rt.m1 == M1_KR)
              s_d.kr = source_one;
            if (s_d.rt.t_ld)
              s_d.tmp = add_result;
          end
        end
      end
      ST_FRESH:
      begin
        // Repeated line-fill addresses do not release the stall
        if (!address_strobe_n && !repeated_addr)
        begin
          if (s_q.rdy != 4'h0)
            s_d.st = ST_BUS;
          else if (s_q.cnt != 4'h0)
            s_d.st = ST_CNT;
          else
          begin
            s_d.st = ST_IDLE;
            s_d.done = 1'b1;
          end
        end
      end
      ST_BUS:
      begin
        if (!burst_ready_n)
        begin
          s_d.rdy = s_q.rdy - 4'h1;
          if (s_q.rdy == 4'h1)
          begin
            if (s_q.cnt != 4'h0)
              s_d.st = ST_CNT;
            else
            begin
              s_d.st = ST_IDLE;
              s_d.done = 1'b1;
            end
          end
        end
      end
      ST_CNT:
      begin
        s_d.cnt = s_q.cnt - 4'h1;
        if (s_q.cnt == 4'h1)
        begin
          s_d.st = ST_IDLE;
          s_d.done = 1'b1;
        end
      end
      default:
      begin
        s_d.st = ST_IDLE;
      end
    endcase
    s_d.ready = (s_d.st == ST_IDLE);
    s_d.frz = (s_d.st != ST_IDLE);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.ready <= 1'b1;
      s_q.ctrl <= CTRL_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign prdata      = s_q.prdata;
  assign pready      = s_q.pready;
  assign pslverr     = s_q.pslverr;
  assign mul_op1_sel = s_q.rt.m1;
  assign add_op1_sel = s_q.rt.a1;
  assign add_op2_sel = s_q.rt.a2;
  assign issue_ready = s_q.ready;
  assign issue_done  = s_q.done;
  assign freeze      = s_q.frz;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_one_clock: assert property (
    acc && ext_w == 4'h0 && rdy_w == 4'h0 && !fresh_w
    |=> issue_done && issue_ready)
    else $error("plain instruction not done in one clock");

  a_drain_set: assert property (
    acc && scalar_issue && !scalar_dmul |=> s_q.drain == 3'h2 ##1
    s_q.drain == 3'h1 ##1 s_q.drain == 3'h0)
    else $error("scalar drain window wrong");

  a_drain_stall: assert property (
    acc && fp_consumer && s_q.drain == 3'h2 && !drain_adj
    && n_w == CLK_ONE && !tlb_miss && !call_miss && !icache_miss
    && rdy_w == 4'h0 && !fresh_w
    |=> freeze [*2] ##1 issue_done)
    else $error("spacing stall not two clocks");

  a_dual_max: assert property (
    acc && dual_on && fb == CLK_THREE && fa == CLK_ONE
    && rdy_w == 4'h0 && !fresh_w |=> s_q.cnt >= 4'h2)
    else $error("dual pair shorter than slower member");

  a_mul_op1: assert property (
    acc && dp_valid && !datapath_control_code[3]
    |=> mul_op1_sel == ($past(datapath_control_code[2]) ? M1_KI : M1_KR))
    else $error("multiplier first operand wrong");

  a_kload_pick: assert property (
    acc && dp_valid && datapath_control_code == 4'h5
    |=> s_q.ki == $past(source_one) && $stable(s_q.kr))
    else $error("wrong constant register loaded");

  a_bc_taken: assert property (
    acc && slot_a_class == CL_BC && slot_a_taken && ext_w == 4'h1
    && rdy_w == 4'h0 && !fresh_w |=> freeze ##1 issue_done)
    else $error("taken branch not two clocks");

  a_bte_taken: assert property (
    acc && slot_a_class == CL_BTE && slot_a_taken && ext_w == 4'h2
    && rdy_w == 4'h0 && !fresh_w |=> freeze [*2] ##1 issue_done)
    else $error("taken compare branch not three clocks");

  a_tlb_floor: assert property (
    acc && tlb_miss |=> !issue_ready [*5])
    else $error("translation miss shorter than five clocks");

  a_fresh_hold: assert property (
    s_q.st == ST_FRESH && (address_strobe_n || repeated_addr)
    |=> s_q.st == ST_FRESH)
    else $error("fresh address stall released early");

  a_freeze_hold: assert property (
    freeze |=> $stable(mul_op1_sel) && $stable(s_q.tmp))
    else $error("issue state changed while frozen");

  c_dual_pair: cover property (acc && dual_on);
  c_bus_wait: cover property (s_q.st == ST_BUS ##1 issue_done);
  c_fresh_wait: cover property (s_q.st == ST_FRESH ##1 s_q.st == ST_BUS);
  c_line_fill: cover property (s_q.beat == LINE_BEATS);
endmodule : dpit_issue_timing

// ### dpit_bus_model.sv
// Bus stand-in for the issue timing bench: one strobe, four readies.
// Assumes a one-cycle go pulse from the bench; idle strobe and ready pins sit high.
`timescale 1ns/1ps
module dpit_bus_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Bench control
  input  wire logic       go,
  input  wire logic [3:0] dly,
  input  wire logic       rep,
  // Bus pins
  output logic            address_strobe_n,
  output logic            burst_ready_n,
  output logic            repeated_addr
);
  logic       act_q;
  logic [4:0] cnt_q;
  logic [4:0] nx;
  logic       rdy;
  assign nx  = cnt_q + 5'h01;
  assign rdy = act_q && nx >= {1'b0, dly} && nx < {1'b0, dly} + 5'h04;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      act_q            <= 1'b0;
      cnt_q            <= 5'h00;
      address_strobe_n <= 1'b1;
      burst_ready_n    <= 1'b1;
      repeated_addr    <= 1'b0;
    end
    else
    begin
      address_strobe_n <= !(go && !act_q);
      // Qualifier is meaningless off the strobe, so it toggles there
      repeated_addr    <= (go && !act_q) ? rep : !repeated_addr;
      burst_ready_n    <= !rdy;
      cnt_q            <= act_q ? nx : 5'h00;
      if (go && !act_q)
        act_q <= 1'b1;
      else if (nx == {1'b0, dly} + 5'h04)
        act_q <= 1'b0;
    end
  end
endmodule : dpit_bus_model

// ### dpit_issue_timing_test.sv
// Self-checking bench for the dual-op issue timing block.
// Assumes the bus stand-in answers every strobe with four readies.
`timescale 1ns/1ps
module dpit_issue_timing_test;
  import dpit_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, source_one = '0, add_result = '0;
  logic [31:0] prdata, d, s, a, kr, ki, tm;
  logic pready, pslverr, er, issue_ready, issue_done, freeze, rep = 0;
  logic address_strobe_n, burst_ready_n, repeated_addr, kick = 0;
  logic issue_valid = 0, dual_valid = 0, dp_valid = 0;
  logic slot_a_taken = 0, slot_a_prior_arith = 0, slot_a_next_ma = 0;
  logic slot_a_next_g = 0, slot_a_move = 0, slot_b_taken = 0;
  logic slot_b_prior_arith = 0, slot_b_next_ma = 0, slot_b_next_g = 0;
  logic slot_b_move = 0, dload_miss = 0, dload_128 = 0, scalar_issue = 0;
  logic scalar_dmul = 0, fp_consumer = 0, prec_overlap = 0;
  logic pipe_dest_nonzero = 0, tlb_miss = 0, abit_update = 0;
  logic icache_miss = 0, line_has_ctl = 0, dcache_busy = 0, dcache_hit = 0;
  logic addr_waiting = 0, wb_waiting = 0, bus_pipe_full = 0;
  logic [1:0] stores_waiting = '0;
  logic [3:0] datapath_control_code = '0, dly = 4'h3;
  logic [4:0] fa, fb;
  logic [6:0] st [5] = '{7'h45, 7'h40, 7'h26, 7'h14, 7'h0E};
  int dl [8] = '{0, 3, 2, 1, 6, 7, 1, 2};
  dpit_class_t slot_a_class = CL_PLAIN, slot_b_class = CL_PLAIN, ca, cb;
  dpit_m1_t mul_op1_sel;
  dpit_a1_t add_op1_sel;
  dpit_a2_t add_op2_sel;
  dpit_route_t r;
  int err_count = 0, check_count = 0, n, nb, e, x, y;
  int seed = 32'hac694bce;

  dpit_issue_timing u_dut (.*);
  dpit_bus_model u_bus (.pclk(pclk), .presetn(presetn), .go(kick),
    .dly(dly), .rep(rep), .address_strobe_n(address_strobe_n),
    .burst_ready_n(burst_ready_n), .repeated_addr(repeated_addr));

  always #10 pclk = ~pclk;

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string w, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", w, exp, seen);
    end
  endtask : chk

  task automatic tmo(input int i, lim);
    if (i >= lim)
    begin
      err_count++;
      report_and_stop;
    end
  endtask : tmo

  // One idle edge first, so psel is never assigned twice in a step
  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge pclk);
      if (pready)
        break;
    end
    tmo(i, 50);
    d = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // n = edges from acceptance to the edge that sees issue_done
  task automatic issue;
    int i;
    issue_valid <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge pclk);
      if (issue_ready)
        break;
    end
    tmo(i, 50);
    issue_valid <= 1'b0;
    kick <= 1'b0;
    for (n = 1; n < 200; n++)
    begin
      @(posedge pclk);
      if (issue_done)
        break;
      chk("frozen", {freeze, issue_ready}, 2'b10);
    end
    tmo(n, 200);
  endtask : issue

  // f holds taken, prior arith, next reader, next graphics, move
  function automatic int clk_of(input dpit_class_t c, input logic [4:0] f);
    case (c)
      CL_BC:    return (f[4] ? 2 : 1) + f[3];
      CL_BCT:   return (f[4] ? 1 : 2) + f[3];
      CL_LOOP:  return f[4] ? 1 : 2;
      CL_BTE:   return f[4] ? 3 : 1;
      CL_BRI:   return 2;
      CL_CALL:  return 1 + f[2];
      CL_CALLI: return 2 + f[2];
      CL_GFX:   return 1 + (f[2] | f[1]);
      CL_LADD:  return 1 + (f[2] & !f[0]) + f[1];
      default:  return 1;
    endcase
  endfunction : clk_of

  // Taken is kept for every class; prior arith only for the conditional branches, the other hints for the call, graphics and load classes
  function automatic logic [4:0] msk(input dpit_class_t c,
                                     input logic [4:0] f);
    if (c == CL_BC || c == CL_BCT)
      return f & 5'h18;
    if (c inside {CL_CALL, CL_CALLI, CL_GFX, CL_LADD})
      return f & 5'h17;
    return f & 5'h10;
  endfunction : msk

  function automatic dpit_route_t rte(input logic [3:0] c);
    dpit_route_t q;
    q = '{M1_KR, A1_SOURCE_ONE, A2_MRES, 1'b0, 1'b0};
    if (!c[3])
      q = '{c[2] ? M1_KI : M1_KR, c[0] ? A1_TEMP : A1_SOURCE_ONE,
            c[1] ? A2_ARES : A2_MRES, c[0], c[1]};
    else if (c[2:0] == 3'h0)
      q = '{M1_KR, A1_ARES, A2_SOURCE_ONE, 1'b0, 1'b0};
    else if (c[2:0] == 3'h1)
      q = '{M1_SOURCE_ONE, A1_SOURCE_TWO, A2_MRES, 1'b0, 1'b0};
    else if (c[2:0] == 3'h3)
      q = '{M1_SOURCE_ONE, A1_TEMP, A2_ARES, 1'b0, 1'b1};
    return q;
  endfunction : rte

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFF_CTRL, 0);
    chk("ctrl", d, 32'h3);
    apb(0, 8'h20, 0);
    chk("unmapped", {er, d[30:0]}, 32'h80000000);
    kr = $random(seed);
    ki = $random(seed);
    tm = 0;
    apb(1, OFF_KR, kr);
    apb(1, OFF_KI, ki);
    dp_valid <= 1'b1;
    for (e = 0; e < 16; e++)
    begin
      s = $random(seed);
      a = $random(seed);
      r = rte(4'(e));
      datapath_control_code <= 4'(e);
      source_one <= s;
      add_result <= a;
      issue;
      if (r.k_ld && r.m1 == M1_KI) ki = s;
      if (r.k_ld && r.m1 == M1_KR) kr = s;
      if (r.t_ld) tm = a;
      chk("mul op1", mul_op1_sel, r.m1);
      chk("add op1", add_op1_sel, r.a1);
      chk("add op2", add_op2_sel, r.a2);
      apb(0, OFF_KR, 0);
      chk("real const", d, kr);
      apb(0, OFF_KI, 0);
      chk("imag const", d, ki);
      apb(0, OFF_TEMP, 0);
      chk("temp", d, tm);
    end
    dp_valid <= 1'b0;
    $display("routing test done");
    for (e = 0; e < 60; e++)
    begin
      ca = dpit_class_t'(4'($unsigned($random(seed)) % 11));
      cb = dpit_class_t'(4'($unsigned($random(seed)) % 11));
      fa = msk(ca, 5'($random(seed)));
      fb = msk(cb, 5'($random(seed)));
      slot_a_class <= ca;
      slot_b_class <= cb;
      {slot_a_taken, slot_a_prior_arith, slot_a_next_ma} <= fa[4:2];
      {slot_a_next_g, slot_a_move} <= fa[1:0];
      {slot_b_taken, slot_b_prior_arith, slot_b_next_ma} <= fb[4:2];
      {slot_b_next_g, slot_b_move} <= fb[1:0];
      dual_valid <= 1'($random(seed));
      issue;
      x = clk_of(ca, fa);
      y = dual_valid && clk_of(cb, fb) > x ? clk_of(cb, fb) : x;
      chk("clocks", n, y);
    end
    apb(1, OFF_CTRL, 32'h1);
    slot_a_class <= CL_BR;
    slot_b_class <= CL_BTE;
    {slot_a_taken, slot_a_prior_arith, slot_a_next_ma} <= 3'h0;
    {slot_a_next_g, slot_a_move, slot_b_taken} <= 3'h1;
    dual_valid <= 1'b1;
    issue;
    chk("single mode", n, 1);
    apb(1, OFF_CTRL, 32'h3);
    $display("timing test done");
    for (e = 0; e < 8; e++)
    begin
      slot_a_class <= CL_FP;
      dual_valid <= 1'b0;
      {scalar_issue, scalar_dmul, fp_consumer} <= {1'b1, e[0], 1'b0};
      {prec_overlap, pipe_dest_nonzero} <= 2'h0;
      issue;
      {scalar_issue, fp_consumer} <= 2'h1;
      {prec_overlap, pipe_dest_nonzero} <= {e[1], e[2]};
      issue;
      if (e == 0) nb = n;
      chk("drain", n, nb + e[0] + (e[1] | e[2]));
    end
    chk("drain wait", nb, 2);
    $display("drain test done");
    for (e = 0; e < 8; e++)
    begin
      slot_a_class <= e > 5 ? CL_CALL : CL_PLAIN;
      {icache_miss, line_has_ctl, fp_consumer} <= {e < 4, e == 1, 1'b0};
      {dcache_busy, dcache_hit} <= {e == 2 || e == 3, e == 3};
      {tlb_miss, abit_update} <= {e == 4 || e == 5, e == 5};
      {dload_miss, dload_128} <= {e > 5, e == 7};
      // Let the previous burst finish, stray readies would count
      repeat (4) @(posedge pclk);
      kick <= 1'b1;
      issue;
      if (e == 0) nb = n;
      chk("fetch wait", nb, dly + 2);
      chk("bus wait", n - nb, dl[e]);
    end
    for (e = 1; e < 8; e += 4)
    begin
      dly <= 4'(e);
      kick <= 1'b1;
      @(posedge pclk);
      kick <= 1'b0;
      repeat (14) @(posedge pclk);
      apb(0, OFF_R1, 0);
      chk("first ready", d, e + 1);
      apb(0, OFF_R2, 0);
      chk("second ready", d, e + 2);
      apb(0, OFF_RL, 0);
      chk("last ready", d, e + 4);
    end
    $display("bus test done");
    for (e = 0; e < 5; e++)
    begin
      {addr_waiting, stores_waiting, wb_waiting} <= st[e][6:3];
      bus_pipe_full <= st[e][2];
      apb(0, OFF_STATUS, 0);
      chk("path full", d[4:3], st[e][1:0]);
    end
    slot_a_class <= CL_PLAIN;
    {dload_miss, addr_waiting, rep, kick} <= 4'h7;
    // Repeated strobe must not release the stall
    fork
      issue;
      begin
        repeat (12) @(posedge pclk);
        {rep, kick} <= 2'h1;
        @(posedge pclk);
        kick <= 1'b0;
      end
    join
    chk("fresh addr", n, 14);
    $display("path test done");
    report_and_stop;
  end
endmodule : dpit_issue_timing_test
